// ===== core/tafl_pkg.sv
// shared constants for the threshold alert and fault logic
package tafl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // data widths
    localparam int POWER_WIDTH = 24;           // computed power result
    localparam int MEAS_WIDTH = 12;            // sense, input voltage, aux
    localparam int REG_WIDTH = 8;              // every register is one byte
    localparam int ADDR_WIDTH = 8;             // register address on the port
    localparam int ADDR_USED = 6;              // address msbs b7-b6 ignored

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [5:0] ADDR_ENABLES = 6'h01;   // threshold_alert_enables
    localparam logic [5:0] ADDR_STATUS = 6'h02;    // live_threshold_status
    localparam logic [5:0] ADDR_FAULTS = 6'h03;    // latched_threshold_faults

    ////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] ENABLES_RESET = 8'h00;  // every alert disarmed
    localparam logic [7:0] STATUS_RESET = 8'h00;   // nothing out of range
    localparam logic [7:0] FAULTS_RESET = 8'h00;   // no fault recorded
    localparam logic [7:0] READ_IDLE = 8'h00;      // unmapped or idle read

    ////////////////////////////////////////////////////////////////////////
    // bit positions, shared by enables, status and faults
    localparam int BIT_POWER_OVER = 7;
    localparam int BIT_POWER_UNDER = 6;
    localparam int BIT_SENSE_OVER = 5;
    localparam int BIT_SENSE_UNDER = 4;
    localparam int BIT_VIN_OVER = 3;
    localparam int BIT_VIN_UNDER = 2;
    localparam int BIT_AUX_OVER = 1;
    localparam int BIT_AUX_UNDER = 0;

    ////////////////////////////////////////////////////////////////////////
    // read answer latency in clock cycles
    localparam int READ_LATENCY = 1;

endpackage

// ===== core/tafl_cmp_if.sv
`timescale 1ns/100ps
// carries measurements and thresholds to the comparator and results back
interface tafl_cmp_if #(
    parameter int PW = 24,
    parameter int MW = 12
);
    logic [PW-1:0] power_value;        // present power result
    logic [PW-1:0] power_max_thr;      // upper power threshold
    logic [PW-1:0] power_min_thr;      // lower power threshold
    logic [MW-1:0] sense_value;        // present current-sense value
    logic [MW-1:0] sense_max_thr;
    logic [MW-1:0] sense_min_thr;
    logic [MW-1:0] vin_value;          // present monitored input voltage
    logic [MW-1:0] vin_max_thr;
    logic [MW-1:0] vin_min_thr;
    logic [MW-1:0] aux_value;          // present auxiliary input
    logic [MW-1:0] aux_max_thr;
    logic [MW-1:0] aux_min_thr;
    logic [7:0] status_now;            // combinational comparison results

    // comparator side
    modport cmp (
        input power_value, power_max_thr, power_min_thr,
        input sense_value, sense_max_thr, sense_min_thr,
        input vin_value, vin_max_thr, vin_min_thr,
        input aux_value, aux_max_thr, aux_min_thr,
        output status_now
    );

    // register side
    modport regs (
        output power_value, power_max_thr, power_min_thr,
        output sense_value, sense_max_thr, sense_min_thr,
        output vin_value, vin_max_thr, vin_min_thr,
        output aux_value, aux_max_thr, aux_min_thr,
        input status_now
    );
endinterface

// ===== core/tafl_compare.sv
`timescale 1ns/100ps
// strict over and under comparisons for all four quantities
module tafl_compare (
    tafl_cmp_if.cmp cmp
);

    ////////////////////////////////////////////////////////////////////////
    // power against its two thresholds, 24 bits
    assign cmp.status_now[tafl_pkg::BIT_POWER_OVER] =
        (cmp.power_value > cmp.power_max_thr);
    assign cmp.status_now[tafl_pkg::BIT_POWER_UNDER] =
        (cmp.power_value < cmp.power_min_thr);

    ////////////////////////////////////////////////////////////////////////
    // current sense, 12 bits
    assign cmp.status_now[tafl_pkg::BIT_SENSE_OVER] =
        (cmp.sense_value > cmp.sense_max_thr);
    assign cmp.status_now[tafl_pkg::BIT_SENSE_UNDER] =
        (cmp.sense_value < cmp.sense_min_thr);

    ////////////////////////////////////////////////////////////////////////
    // monitored input voltage, 12 bits
    assign cmp.status_now[tafl_pkg::BIT_VIN_OVER] =
        (cmp.vin_value > cmp.vin_max_thr);
    assign cmp.status_now[tafl_pkg::BIT_VIN_UNDER] =
        (cmp.vin_value < cmp.vin_min_thr);

    ////////////////////////////////////////////////////////////////////////
    // auxiliary input, 12 bits
    assign cmp.status_now[tafl_pkg::BIT_AUX_OVER] =
        (cmp.aux_value > cmp.aux_max_thr);
    assign cmp.status_now[tafl_pkg::BIT_AUX_UNDER] =
        (cmp.aux_value < cmp.aux_min_thr);

endmodule

// ===== core/tafl_threshold_alert.sv
`timescale 1ns/100ps
//
// Contract
// - power above maximum raises enabled alert
// - power below minimum raises enabled alert
// - sense over and under have own enables
// - input voltage over and under have enables
// - auxiliary over and under have own enables
// - all eight enables reset to zero
// - enable register at address one, read/write
// - status bit seven shows power over maximum
// - status bit six shows power under minimum
// - status bits five, four show sense
// - status bits three, two show voltage
// - status bits one, zero show auxiliary
// - status at address two, read only
// - fault bits seven, six record power
// - fault bits five, four record sense
// - fault bits three, two record voltage
// - fault bits one, zero record auxiliary
// - fault register at address three, read/write
// - power is 24 bits, others 12
//
module tafl_threshold_alert #(
    parameter int POWER_W = tafl_pkg::POWER_WIDTH,
    parameter int MEAS_W = tafl_pkg::MEAS_WIDTH
) (
    // core clock and reset
    input wire logic mclk,
    input wire logic rst,
    // power result and its thresholds
    input wire logic [POWER_W-1:0] power_value,
    input wire logic [POWER_W-1:0] power_max_thr,
    input wire logic [POWER_W-1:0] power_min_thr,
    // current-sense measurement and thresholds
    input wire logic [MEAS_W-1:0] sense_value,
    input wire logic [MEAS_W-1:0] sense_max_thr,
    input wire logic [MEAS_W-1:0] sense_min_thr,
    // monitored input voltage and thresholds
    input wire logic [MEAS_W-1:0] monitored_input_voltage,
    input wire logic [MEAS_W-1:0] monitored_input_voltage_max_thr,
    input wire logic [MEAS_W-1:0] monitored_input_voltage_min_thr,
    // auxiliary input and thresholds
    input wire logic [MEAS_W-1:0] auxiliary_input,
    input wire logic [MEAS_W-1:0] auxiliary_input_max_thr,
    input wire logic [MEAS_W-1:0] auxiliary_input_min_thr,
    // register port from the bus engine
    input wire logic [tafl_pkg::ADDR_WIDTH-1:0] reg_addr,
    input wire logic [tafl_pkg::REG_WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tafl_pkg::REG_WIDTH-1:0] reg_rdata,
    output logic reg_rdata_valid,
    // alert, open drain, plus a plain level copy
    output logic alert_pin_o,
    output logic alert_pin_oe_n,
    output logic alert_active
);

    ////////////////////////////////////////////////////////////////////////
    // address decoding

    // true when the low address bits select the given register
    function automatic logic addr_hit(
        input logic [tafl_pkg::ADDR_WIDTH-1:0] addr,
        input logic [tafl_pkg::ADDR_USED-1:0] target
    );
        // msbs above the used field are ignored
        addr_hit = (addr[tafl_pkg::ADDR_USED-1:0] == target);
    endfunction

    // register selects
    wire sel_enables;       // alert enable register
    wire sel_status;        // live status register
    wire sel_faults;        // latched fault register
    assign sel_enables = addr_hit(reg_addr, tafl_pkg::ADDR_ENABLES);
    assign sel_status = addr_hit(reg_addr, tafl_pkg::ADDR_STATUS);
    assign sel_faults = addr_hit(reg_addr, tafl_pkg::ADDR_FAULTS);

    // write strobes per register
    wire wr_enables;        // host writes the enables
    wire wr_faults;         // host writes the faults
    assign wr_enables = reg_wr & sel_enables;
    assign wr_faults = reg_wr & sel_faults;
    // note: a write to the status address has no strobe at all

    ////////////////////////////////////////////////////////////////////////
    // register state

    // alert enables, one per comparison
    logic [tafl_pkg::REG_WIDTH-1:0] threshold_alert_enables;
    // live comparison results, refreshed every cycle
    logic [tafl_pkg::REG_WIDTH-1:0] live_threshold_status;
    // sticky record of tripped comparisons
    logic [tafl_pkg::REG_WIDTH-1:0] latched_threshold_faults;

    // next values
    logic [tafl_pkg::REG_WIDTH-1:0] next_enables;
    logic [tafl_pkg::REG_WIDTH-1:0] next_faults;
    logic [tafl_pkg::REG_WIDTH-1:0] next_rdata;
    logic next_alert;

    ////////////////////////////////////////////////////////////////////////
    // comparator hookup

    // bundle to the comparator
    tafl_cmp_if #(
        .PW(POWER_W),
        .MW(MEAS_W)
    ) cmp_bus ();

    // feed measurements and thresholds, same clock domain, no sync
    assign cmp_bus.power_value = power_value;
    assign cmp_bus.power_max_thr = power_max_thr;
    assign cmp_bus.power_min_thr = power_min_thr;
    assign cmp_bus.sense_value = sense_value;
    assign cmp_bus.sense_max_thr = sense_max_thr;
    assign cmp_bus.sense_min_thr = sense_min_thr;
    assign cmp_bus.vin_value = monitored_input_voltage;
    assign cmp_bus.vin_max_thr = monitored_input_voltage_max_thr;
    assign cmp_bus.vin_min_thr = monitored_input_voltage_min_thr;
    assign cmp_bus.aux_value = auxiliary_input;
    assign cmp_bus.aux_max_thr = auxiliary_input_max_thr;
    assign cmp_bus.aux_min_thr = auxiliary_input_min_thr;

    // strict greater-than and less-than for all eight bits
    tafl_compare u_compare (
        .cmp(cmp_bus.cmp)
    );

    // present comparison results
    wire [tafl_pkg::REG_WIDTH-1:0] status_now;
    assign status_now = cmp_bus.status_now;

    ////////////////////////////////////////////////////////////////////////
    // alert enable register

    // whole byte written by the host, otherwise held
    assign next_enables = wr_enables ? reg_wdata : threshold_alert_enables;

    // enables clear at reset, so nothing alerts until armed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            threshold_alert_enables <= tafl_pkg::ENABLES_RESET;
        end else begin
            threshold_alert_enables <= next_enables;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live status register

    // follows the comparator every cycle, host writes ignored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            live_threshold_status <= tafl_pkg::STATUS_RESET;
        end else begin
            live_threshold_status <= status_now;
        end
    end
    // bit seven is power over, bit six power under
    // bits five and four carry the sense comparisons
    // bits three and two carry the input voltage comparisons
    // bits one and zero carry the auxiliary comparisons

    ////////////////////////////////////////////////////////////////////////
    // latched fault register

    // per bit: a trip sets, a host zero clears, a host one does nothing
    genvar gi;
    generate
        for (gi = 0; gi < tafl_pkg::REG_WIDTH; gi = gi + 1) begin : g_fault
            // host asks to clear this bit
            wire clear_req;
            assign clear_req = wr_faults & ~reg_wdata[gi];
            // a trip in the clearing cycle wins over the clear
            assign next_faults[gi] = status_now[gi] |
                (latched_threshold_faults[gi] & ~clear_req);
        end
    endgenerate
    // power bits seven and six latch the power trips
    // sense bits five and four latch the sense trips
    // voltage bits three and two latch the voltage trips
    // auxiliary bits one and zero latch the auxiliary trips

    // fault storage, clear at reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            latched_threshold_faults <= tafl_pkg::FAULTS_RESET;
        end else begin
            latched_threshold_faults <= next_faults;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alert generation

    // any recorded fault whose enable is armed, on the coming values
    assign next_alert = |(next_faults & next_enables);

    // alert level and open-drain pin, both registered
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            alert_active <= 1'b0;
            alert_pin_o <= 1'b0;
            alert_pin_oe_n <= 1'b1;
        end else begin
            alert_active <= next_alert;
            // pin only ever pulls low
            alert_pin_o <= 1'b0;
            // enable low means the pin is driven low
            alert_pin_oe_n <= ~next_alert;
        end
    end
    // power over and under reach the pin through their enables
    // sense, voltage and auxiliary do the same

    ////////////////////////////////////////////////////////////////////////
    // read path

    // read mux of the present register values
    always_comb begin
        next_rdata = tafl_pkg::READ_IDLE;
        if (reg_rd) begin
            // enables read back what was written
            if (sel_enables) begin
                next_rdata = threshold_alert_enables;
            // status shows the live comparisons
            end else if (sel_status) begin
                next_rdata = live_threshold_status;
            // faults show the sticky record
            end else if (sel_faults) begin
                next_rdata = latched_threshold_faults;
            end else begin
                // unmapped address reads zero
                next_rdata = tafl_pkg::READ_IDLE;
            end
        end
    end

    // read data and its valid strobe, one cycle after the request
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= tafl_pkg::READ_IDLE;
            reg_rdata_valid <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            reg_rdata_valid <= reg_rd;
        end
    end

endmodule

// ===== test/tafl_threshold_alert_asserts.sv
`timescale 1ns/100ps
// watches the top ports for register and alert behaviour
module tafl_threshold_alert_asserts #(
    parameter int POWER_W = 24,
    parameter int MEAS_W = 12
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [POWER_W-1:0] power_value,
    input wire logic [POWER_W-1:0] power_max_thr,
    input wire logic [POWER_W-1:0] power_min_thr,
    input wire logic [MEAS_W-1:0] sense_value,
    input wire logic [MEAS_W-1:0] sense_max_thr,
    input wire logic [MEAS_W-1:0] sense_min_thr,
    input wire logic [MEAS_W-1:0] monitored_input_voltage,
    input wire logic [MEAS_W-1:0] monitored_input_voltage_max_thr,
    input wire logic [MEAS_W-1:0] monitored_input_voltage_min_thr,
    input wire logic [MEAS_W-1:0] auxiliary_input,
    input wire logic [MEAS_W-1:0] auxiliary_input_max_thr,
    input wire logic [MEAS_W-1:0] auxiliary_input_min_thr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid,
    input wire logic alert_pin_o,
    input wire logic alert_pin_oe_n,
    input wire logic alert_active
);
    ////////////////////////////////////////
    // strict comparisons, status bit order
    wire [7:0] cmp_now;
    assign cmp_now = {power_value > power_max_thr, power_value < power_min_thr,
        sense_value > sense_max_thr, sense_value < sense_min_thr,
        monitored_input_voltage > monitored_input_voltage_max_thr,
        monitored_input_voltage < monitored_input_voltage_min_thr,
        auxiliary_input > auxiliary_input_max_thr, auxiliary_input < auxiliary_input_min_thr};
    // any comparison out of range this cycle
    wire cmp_any;
    assign cmp_any = |cmp_now;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // single register accesses
    sequence s_rd(logic [5:0] a);
        reg_rd && !reg_wr && reg_addr[5:0] == a;
    endsequence
    sequence s_wr(logic [5:0] a);
        reg_wr && !reg_rd && reg_addr[5:0] == a;
    endsequence

    ////////////////////////////////////////
    property p_pin;
        alert_pin_o == 1'b0 && alert_pin_oe_n == !alert_active;
    endproperty
    a_pin: assert property (p_pin) else $error("alert pin disagrees with level");
    property p_rd_lat;
        reg_rd |=> reg_rdata_valid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer missing");
    property p_idle;
        !reg_rd |=> !reg_rdata_valid && reg_rdata == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_status;
        (s_rd(6'h02) ##0 !$past(rst)) |=> reg_rdata == $past(cmp_now, 2);
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_unmapped;
        reg_rd && (reg_addr[5:0] == 6'h00 || reg_addr[5:0] > 6'h03) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_en_rw;
        s_wr(6'h01) ##1 !reg_wr ##1 s_rd(6'h01) |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_en_rw: assert property (p_en_rw) else $error("enables readback wrong");
    property p_rise;
        $rose(alert_active) |-> $past(reg_wr) || $past(cmp_any);
    endproperty
    a_rise: assert property (p_rise) else $error("alert rose without cause");
    property p_fall;
        $fell(alert_active) |-> $past(reg_wr);
    endproperty
    a_fall: assert property (p_fall) else $error("alert fell without write");
    property p_fault_clr;
        (s_wr(6'h03) ##0 reg_wdata == 8'h00 && cmp_now == 8'h00) ##1
            (!reg_wr && cmp_now == 8'h00) ##1 s_rd(6'h03) |=> reg_rdata == 8'h00;
    endproperty
    a_fault_clr: assert property (p_fault_clr) else $error("faults not cleared");
endmodule

bind tafl_threshold_alert tafl_threshold_alert_asserts #(.POWER_W(POWER_W), .MEAS_W(MEAS_W))
    u_tafl_chk (.*);

// ===== test/tafl_host_model.sv
`timescale 1ns/100ps
// host behind the bus engine: one-cycle strobes at the falling edge
module tafl_host_model (
    input wire logic mclk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_valid
);
    // idle bus at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // one write; released lines show inverted values
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    // one read; waits a bounded time for the valid pulse
    task rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        n = 0;
        while (reg_rdata_valid !== 1'b1 && n < 3) begin
            @(negedge mclk);
            n++;
        end
        d = (reg_rdata_valid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/100ps
// self-checking bench for the threshold alert and fault logic
module testbench;
    logic mclk;
    logic rst;
    logic [23:0] pv, px, pn;
    logic [11:0] mv [3];
    logic [11:0] mx [3];
    logic [11:0] mn [3];
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, m;
    logic reg_wr, reg_rd, reg_rdata_valid, alert_pin_o, alert_pin_oe_n, alert_active;
    wire alert_wire = alert_pin_oe_n ? 1'b1 : alert_pin_o; // pulled up when released
    int bad_count = 0;
    int n_checks = 0;

    tafl_threshold_alert i_tafl_threshold_alert (
        .mclk(mclk), .rst(rst),
        .power_value(pv), .power_max_thr(px), .power_min_thr(pn),
        .sense_value(mv[0]), .sense_max_thr(mx[0]), .sense_min_thr(mn[0]),
        .monitored_input_voltage(mv[1]), .monitored_input_voltage_max_thr(mx[1]),
        .monitored_input_voltage_min_thr(mn[1]),
        .auxiliary_input(mv[2]), .auxiliary_input_max_thr(mx[2]),
        .auxiliary_input_min_thr(mn[2]),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
        .alert_pin_o(alert_pin_o), .alert_pin_oe_n(alert_pin_oe_n), .alert_active(alert_active)
    );
    tafl_host_model host (
        .mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid)
    );

    ////////////////////////////////////////
    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // compare and count
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // every quantity well inside its window
    task base();
        pv = 24'h001000;
        px = 24'h800000;
        pn = 24'h000100;
        for (int k = 0; k < 3; k++) begin
            mv[k] = 12'h100;
            mx[k] = 12'h800;
            mn[k] = 12'h010;
        end
    endtask
    // move the quantity of bit i d past its threshold
    task automatic poke(input int i, input logic [11:0] d);
        int k;
        k = 2 - i / 2;
        if (k < 0) begin
            pv = (i % 2 == 1) ? px + 24'(d) : pn - 24'(d);
        end else if (i % 2 == 1) begin
            mv[k] = mx[k] + d;
        end else begin
            mv[k] = mn[k] - d;
        end
    endtask
    // verdict and end of run
    task results();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        base();
        repeat (3) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        host.rd(8'h01, v); chk(v, 8'h00);
        host.rd(8'h02, v); chk(v, 8'h00);
        host.rd(8'h03, v); chk(v, 8'h00);
        chk({7'h00, alert_wire}, 8'h01);
        $display("test reset values done");
        host.wr(8'h01, 8'ha5);
        host.rd(8'h01, v); chk(v, 8'ha5);
        host.rd(8'h41, v); chk(v, 8'ha5);
        host.wr(8'h02, 8'hff);
        host.rd(8'h02, v); chk(v, 8'h00);
        host.rd(8'h3f, v); chk(v, 8'h00);
        host.wr(8'h01, 8'h00);
        $display("test register access done");
        // each comparison: boundary, trip, latch, alert, clear
        for (int i = 0; i < 8; i++) begin
            m = 8'h01 << i;
            base();
            poke(i, 12'h000);
            host.rd(8'h02, v); chk(v, 8'h00);
            poke(i, 12'h001);
            host.rd(8'h02, v); chk(v, m);
            base();
            host.rd(8'h02, v); chk(v, 8'h00);
            host.rd(8'h03, v); chk(v, m);
            chk({7'h00, alert_active}, 8'h00);
            host.wr(8'h01, m);
            chk({7'h00, alert_active}, 8'h01);
            chk({7'h00, alert_wire}, 8'h00);
            host.wr(8'h03, 8'hff);
            host.rd(8'h03, v); chk(v, m);
            host.wr(8'h03, 8'h00);
            host.rd(8'h03, v); chk(v, 8'h00);
            chk({7'h00, alert_wire}, 8'h01);
            host.wr(8'h01, 8'h00);
        end
        $display("test comparisons done");
        poke(7, 12'h001);
        host.wr(8'h01, 8'hff);
        chk({7'h00, alert_active}, 8'h01);
        rst = 1'b1;
        repeat (3) @(negedge mclk);
        rst = 1'b0;
        base();
        host.rd(8'h01, v); chk(v, 8'h00);
        host.rd(8'h03, v); chk(v, 8'h00);
        chk({7'h00, alert_active}, 8'h00);
        $display("test second reset done");
        results();
    end
    // hang guard
    initial begin
        #(40 * 4000);
        bad_count++;
        $display("watchdog expired");
        results();
    end
endmodule
